// File: common/vent_pkg.sv
// Purpose: types for the venting output and pressure start block
// Assumes: vent_regs.svh supplies the numbers
// Notes: none
`include "vent_regs.svh"
package vent_pkg;
  typedef struct packed {
    logic [`FREQ_W-1:0] upper;
    logic [`FREQ_W-1:0] lower;
  } thresh_t;
  typedef struct packed {
    logic supply_fail;
    logic stop_cmd;
    logic [`FREQ_W-1:0] freq;
  } vent_in_t;
  typedef struct packed {
    logic [`ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avs_req_t;
endpackage : vent_pkg

// File: common/vent_regs.svh
// Purpose: offsets, field positions, reset values and timing counts for the venting block
// Assumes: Avalon-MM word addressing of 32-bit registers, byte address = 4 * word
// Notes: definitions only
`ifndef VENT_REGS_SVH
`define VENT_REGS_SVH
`define ADDR_W 4
`define OFF_CTRL 4'h0
`define OFF_FUNC 4'h1
`define OFF_UPPER_PF 4'h2
`define OFF_LOWER_PF 4'h3
`define OFF_UPPER_A 4'h4
`define OFF_UPPER_B 4'h5
`define OFF_UPPER_C 4'h6
`define OFF_LOWER_A 4'h7
`define OFF_LOWER_B 4'h8
`define OFF_LOWER_C 4'h9
`define OFF_PSTART_EN 4'hA
`define OFF_PLIMIT 4'hB
`define OFF_STATUS 4'hC
`define CW_START_BIT 0
`define CW_INHIBIT_A_BIT 5
`define CW_INHIBIT_B_BIT 14
`define CW_INHIBIT_C_BIT 15
`define FC_PF_VENT 8'h19
`define FC_STOP_VENT 8'h28
`define FC_COMBINED 8'h29
`define FREQ_W 16
`define PRES_W 16
`define RST_CTRL 16'h0000
`define RST_FUNC 8'h00
`define RST_THRESH 16'h0000
`define RST_PLIMIT 16'h0000
`define SYNC_STAGES 2
`endif

// File: dv/tb_top.sv
// Purpose: directed bench for vent_ctrl
// Assumes: A uses code 25, B code 40, C code 41
// Notes: waits of six edges cover the four-edge pin path
`timescale 1ns/1ps
`include "vent_regs.svh"
module tb_top;
  import vent_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fail = 1'b0;
  logic [15:0] freq = 16'h03E8;
  logic [15:0] pres = 16'h0064;
  avs_req_t req;
  logic wait_r, hung, a, b, c, run;
  logic [31:0] rdata, q;
  int mismatches = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  vent_host vent_host_inst (.clk(clk), .waitreq(wait_r), .rdata(rdata), .req(req), .hung(hung));
  vent_ctrl vent_ctrl_inst (.CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(req.address),
    .AVS_READ(req.read), .AVS_WRITE(req.write), .AVS_WRITEDATA(req.writedata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r), .SUPPLY_FAIL(fail), .ROTOR_FREQ(freq),
    .PRESSURE(pres), .ACCESSORY_OUT_A(a), .ACCESSORY_OUT_B(b), .ACCESSORY_OUT_C(c),
    .PUMP_RUN(run));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  always @(posedge hung) begin
    mismatches++;
    conclude();
  end
  // command first, pins after, so inhibit is in place before the pins move
  task automatic step(input logic f, input logic r, input logic [2:0] i, input logic [15:0] fr,
                      input logic [3:0] e);
    vent_host_inst.cmd(r, i);
    fail <= f;
    freq <= fr;
    repeat (6) @(posedge clk);
    chk({28'h0, a, b, c, run}, {28'h0, e});
  endtask : step
  task automatic press(input logic [15:0] p, input logic e);
    pres <= p;
    repeat (6) @(posedge clk);
    chk({31'h0, run}, {31'h0, e});
  endtask : press
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    vent_host_inst.xfer(1'b1, `OFF_FUNC, 32'h0029_2819, q);
    vent_host_inst.xfer(1'b1, `OFF_UPPER_PF, 32'h320, q);
    vent_host_inst.xfer(1'b1, `OFF_LOWER_PF, 32'hC8, q);
    for (int k = 4; k < 10; k++) vent_host_inst.xfer(1'b1, k[3:0], k < 7 ? 32'h258 : 32'h12C, q);
    vent_host_inst.xfer(1'b0, `OFF_FUNC, 32'h0, q);
    chk(q, 32'h0029_2819);
    vent_host_inst.xfer(1'b0, 4'hD, 32'h0, q);
    chk(q, 32'h0);
    step(1'b0, 1'b1, 3'h0, 16'h3E8, 4'hB);
    step(1'b1, 1'b1, 3'h0, 16'h3E8, 4'hB);
    step(1'b1, 1'b1, 3'h0, 16'h320, 4'hB);
    step(1'b1, 1'b1, 3'h0, 16'h31F, 4'h1);
    step(1'b1, 1'b1, 3'h0, 16'h1F4, 4'h1);
    step(1'b1, 1'b1, 3'h0, 16'hC8, 4'h1);
    step(1'b1, 1'b1, 3'h0, 16'hC7, 4'hB);
    step(1'b0, 1'b0, 3'h0, 16'h3E8, 4'hE);
    step(1'b0, 1'b0, 3'h0, 16'h2BC, 4'hE);
    step(1'b0, 1'b0, 3'h0, 16'h257, 4'hC);
    step(1'b0, 1'b0, 3'h0, 16'h96, 4'hE);
    step(1'b0, 1'b0, 3'h0, 16'h0, 4'hA);
    step(1'b1, 1'b0, 3'h7, 16'h1F4, 4'hA);
    step(1'b1, 1'b0, 3'h0, 16'h1F4, 4'h4);
    step(1'b0, 1'b1, 3'h0, 16'h3E8, 4'h1);
    vent_host_inst.xfer(1'b0, `OFF_STATUS, 32'h0, q);
    chk(q, 32'h0000_0008);
    vent_host_inst.xfer(1'b1, `OFF_PLIMIT, 32'h12C, q);
    vent_host_inst.xfer(1'b1, `OFF_PSTART_EN, 32'h1, q);
    press(16'h64, 1'b1);
    press(16'h12C, 1'b0);
    press(16'h12B, 1'b1);
    vent_host_inst.xfer(1'b1, `OFF_PSTART_EN, 32'h0, q);
    press(16'h12C, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({28'h0, a, b, c, run}, 32'h0);
    vent_host_inst.xfer(1'b0, `OFF_FUNC, 32'h0, q);
    chk(q, 32'h0);
    conclude();
  end
endmodule : tb_top

// File: dv/vent_ctrl_assertions.sv
// Purpose: port checks for vent_ctrl
// Assumes: a register write lands at the first edge of the access, while waitrequest is still high
// Notes: shadows only the control word and the pressure start enable
`timescale 1ns/1ps
`include "vent_regs.svh"
module vent_ctrl_checker (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [`ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic SUPPLY_FAIL,
  input wire logic [`FREQ_W-1:0] ROTOR_FREQ,
  input wire logic [`PRES_W-1:0] PRESSURE,
  input wire logic ACCESSORY_OUT_A,
  input wire logic ACCESSORY_OUT_B,
  input wire logic ACCESSORY_OUT_C,
  input wire logic PUMP_RUN
);
  logic [15:0] ctrl_q;
  logic pen_q;
  logic [2:0] quiet_q;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl_q <= '0;
      pen_q <= 1'b0;
    end else if (AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == `OFF_CTRL) ctrl_q <= AVS_WRITEDATA[15:0];
    else if (AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == `OFF_PSTART_EN) pen_q <= AVS_WRITEDATA[0];
  end
  // pins reach the outputs four edges late, so a margin of five is kept
  always_ff @(posedge CORE_CLK) begin
    if (RESET || AVS_WRITE || $changed(SUPPLY_FAIL) || $changed(ROTOR_FREQ) || $changed(PRESSURE))
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  AST_ANSWER: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("late answer");
  AST_RESET_OUT: assert property (disable iff (1'b0) RESET |=> AVS_WAITREQUEST &&
    !(ACCESSORY_OUT_A || ACCESSORY_OUT_B || ACCESSORY_OUT_C || PUMP_RUN)) else $error("no reset");
  AST_HOLD: assert property (quiet_q > 3'h4 |->
    $stable({ACCESSORY_OUT_A, ACCESSORY_OUT_B, ACCESSORY_OUT_C, PUMP_RUN})) else $error("drift");
  AST_INH_A: assert property (ctrl_q[5] [*3] |=> $stable(ACCESSORY_OUT_A))
    else $error("a moved");
  AST_INH_B: assert property (ctrl_q[14] [*3] |=> $stable(ACCESSORY_OUT_B))
    else $error("b moved");
  AST_INH_C: assert property (ctrl_q[15] [*3] |=> $stable(ACCESSORY_OUT_C))
    else $error("c moved");
  AST_STOP_IDLE: assert property ((!ctrl_q[0]) [*2] |-> !PUMP_RUN)
    else $error("run without start");
  AST_FREE_RUN: assert property ((!pen_q && ctrl_q[0]) [*2] |-> PUMP_RUN)
    else $error("start ignored");
  COV_CUT_A: cover property ($fell(ACCESSORY_OUT_A));
  COV_VENT_B: cover property ($rose(ACCESSORY_OUT_B));
  COV_PRESS: cover property (pen_q && $fell(PUMP_RUN));
endmodule : vent_ctrl_checker
bind vent_ctrl vent_ctrl_checker vent_ctrl_checker_inst (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SUPPLY_FAIL(SUPPLY_FAIL),
  .ROTOR_FREQ(ROTOR_FREQ), .PRESSURE(PRESSURE), .ACCESSORY_OUT_A(ACCESSORY_OUT_A),
  .ACCESSORY_OUT_B(ACCESSORY_OUT_B), .ACCESSORY_OUT_C(ACCESSORY_OUT_C), .PUMP_RUN(PUMP_RUN));

// File: dv/vent_host.sv
// Purpose: supervisory host writing parameters and commands
// Assumes: one access at a time
// Notes: released lines show inverted values so nothing stale passes
`timescale 1ns/1ps
`include "vent_regs.svh"
module vent_host (
  input wire logic clk,
  input wire logic waitreq,
  input wire logic [31:0] rdata,
  output vent_pkg::avs_req_t req,
  output logic hung
);
  import vent_pkg::*;
  initial begin
    req = '0;
    hung = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) hung <= 1'b1;
    req <= '{address: ~a, read: 1'b0, write: 1'b0, writedata: ~d};
    @(posedge clk);
  endtask : xfer
  task automatic cmd(input logic run, input logic [2:0] inh);
    logic [31:0] w;
    logic [31:0] q;
    w = '0;
    w[`CW_START_BIT] = run;
    w[`CW_INHIBIT_A_BIT] = inh[0];
    w[`CW_INHIBIT_B_BIT] = inh[1];
    w[`CW_INHIBIT_C_BIT] = inh[2];
    xfer(1'b1, `OFF_CTRL, w, q);
  endtask : cmd
endmodule : vent_host

// File: rtl/vent_channel.sv
// Purpose: per-output venting decision with hysteresis
// Assumes: inputs already synchronised, thresholds static while in use
// Notes: output holds between crossings
`timescale 1ns/1ps
module vent_channel
  import vent_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] func_code,
  input wire logic inhibit,
  input wire vent_pkg::vent_in_t vin,
  input wire vent_pkg::thresh_t pf_th,
  input wire vent_pkg::thresh_t stop_th,
  output logic out_q
);
  logic latch_q;
  logic latch_d;
  logic out_d;
  logic turning;
  assign turning = vin.freq != '0;
  always_comb begin
    latch_d = latch_q;
    out_d = out_q;
    unique case (func_code)
      `FC_PF_VENT: begin
        // once cut, stay cut until below the lower limit
        if (vin.supply_fail && vin.freq < pf_th.upper) latch_d = 1'b1;
        if (vin.freq < pf_th.lower) latch_d = 1'b0;
        out_d = !latch_d;
      end
      `FC_STOP_VENT: begin
        out_d = vin.stop_cmd && turning;
        latch_d = 1'b0;
      end
      `FC_COMBINED: begin
        if (vin.supply_fail && vin.freq < pf_th.upper) latch_d = 1'b1;
        if (vin.stop_cmd && vin.freq < stop_th.upper) latch_d = 1'b1;
        if (vin.freq < pf_th.lower && !(vin.stop_cmd && vin.freq >= stop_th.lower)) begin
          latch_d = 1'b0;
        end
        out_d = !latch_d;
      end
      default: begin
        latch_d = 1'b0;
        out_d = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= 1'b0;
    end else if (!inhibit) begin
      out_q <= out_d;
    end
  end
endmodule : vent_channel

// File: rtl/vent_ctrl.sv
// Purpose: venting accessory outputs and pressure-gated pump start
// Assumes: supply-fail, frequency and pressure arrive as asynchronous pin levels
// Notes: parameters and control word written over Avalon-MM
//
// Overview of operation
// - code 25: power fail below upper limit cuts the output
// - code 25: below lower limit the output is set again
// - power-fail thresholds come from upper and lower registers in hertz
// - each of three outputs uses its own code and stop thresholds
// - code 40: output is off by default
// - code 40: output on while stop present and rotor turning
// - control word bits 5, 14, 15 freeze outputs a, b, c
// - code 41: output on by default
// - code 41: power fail below upper cuts, below lower restores
// - code 41: stop below upper cuts, below both its own lower and the power-fail lower restores
// - stop-triggered thresholds come from per-output upper and lower registers
// - pressure start enable register: 0 disables, 1 enables
// - pressure limit comes from its own register
// - enabled: pump runs only with start and pressure below limit
`timescale 1ns/1ps
module vent_ctrl
  import vent_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [`ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SUPPLY_FAIL,
  input wire logic [`FREQ_W-1:0] ROTOR_FREQ,
  input wire logic [`PRES_W-1:0] PRESSURE,
  output logic ACCESSORY_OUT_A,
  output logic ACCESSORY_OUT_B,
  output logic ACCESSORY_OUT_C,
  output logic PUMP_RUN
);
  import vent_pkg::*;

  logic [15:0] host_control_word_q;
  logic [7:0] func_q [3];
  logic [`FREQ_W-1:0] upper_pf_q;
  logic [`FREQ_W-1:0] lower_pf_q;
  logic [`FREQ_W-1:0] upper_q [3];
  logic [`FREQ_W-1:0] lower_q [3];
  logic pressure_start_enable_q;
  logic [`PRES_W-1:0] plimit_q;
  logic ack_q;
  logic [31:0] rdata_d;
  logic [`FREQ_W+`PRES_W:0] sync_out;
  logic fail_s;
  logic [`FREQ_W-1:0] freq_s;
  logic [`PRES_W-1:0] pres_s;
  logic [2:0] acc;
  logic [2:0] inhibit;
  logic run_d;
  logic access;

  // pins are asynchronous; a slowly moving bus may be sampled mid-change, harmless here
  vent_sync #(.W(`FREQ_W + `PRES_W + 1)) u_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .din({SUPPLY_FAIL, ROTOR_FREQ, PRESSURE}),
    .dout(sync_out)
  );
  assign {fail_s, freq_s, pres_s} = sync_out;

  // one wait state: every access ends on the second edge
  assign access = (AVS_READ || AVS_WRITE) && !ack_q;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !access;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      host_control_word_q <= `RST_CTRL;
      upper_pf_q <= `RST_THRESH;
      lower_pf_q <= `RST_THRESH;
      pressure_start_enable_q <= 1'b0;
      plimit_q <= `RST_PLIMIT;
      for (int i = 0; i < 3; i++) begin
        func_q[i] <= `RST_FUNC;
        upper_q[i] <= `RST_THRESH;
        lower_q[i] <= `RST_THRESH;
      end
    end else if (AVS_WRITE && access) begin
      unique case (AVS_ADDRESS)
        `OFF_CTRL: host_control_word_q <= AVS_WRITEDATA[15:0];
        `OFF_FUNC: begin
          func_q[0] <= AVS_WRITEDATA[7:0];
          func_q[1] <= AVS_WRITEDATA[15:8];
          func_q[2] <= AVS_WRITEDATA[23:16];
        end
        `OFF_UPPER_PF: upper_pf_q <= AVS_WRITEDATA[15:0];
        `OFF_LOWER_PF: lower_pf_q <= AVS_WRITEDATA[15:0];
        `OFF_UPPER_A: upper_q[0] <= AVS_WRITEDATA[15:0];
        `OFF_UPPER_B: upper_q[1] <= AVS_WRITEDATA[15:0];
        `OFF_UPPER_C: upper_q[2] <= AVS_WRITEDATA[15:0];
        `OFF_LOWER_A: lower_q[0] <= AVS_WRITEDATA[15:0];
        `OFF_LOWER_B: lower_q[1] <= AVS_WRITEDATA[15:0];
        `OFF_LOWER_C: lower_q[2] <= AVS_WRITEDATA[15:0];
        `OFF_PSTART_EN: pressure_start_enable_q <= AVS_WRITEDATA[0];
        `OFF_PLIMIT: plimit_q <= AVS_WRITEDATA[15:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      `OFF_CTRL: rdata_d = {16'h0000, host_control_word_q};
      `OFF_FUNC: rdata_d = {8'h00, func_q[2], func_q[1], func_q[0]};
      `OFF_UPPER_PF: rdata_d = {16'h0000, upper_pf_q};
      `OFF_LOWER_PF: rdata_d = {16'h0000, lower_pf_q};
      `OFF_UPPER_A: rdata_d = {16'h0000, upper_q[0]};
      `OFF_UPPER_B: rdata_d = {16'h0000, upper_q[1]};
      `OFF_UPPER_C: rdata_d = {16'h0000, upper_q[2]};
      `OFF_LOWER_A: rdata_d = {16'h0000, lower_q[0]};
      `OFF_LOWER_B: rdata_d = {16'h0000, lower_q[1]};
      `OFF_LOWER_C: rdata_d = {16'h0000, lower_q[2]};
      `OFF_PSTART_EN: rdata_d = {31'h0000_0000, pressure_start_enable_q};
      `OFF_PLIMIT: rdata_d = {16'h0000, plimit_q};
      `OFF_STATUS: rdata_d = {16'h0000, 11'h000, fail_s, PUMP_RUN, acc};
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && access) begin
      AVS_READDATA <= rdata_d;
    end
  end

  assign inhibit = {host_control_word_q[`CW_INHIBIT_C_BIT],
                    host_control_word_q[`CW_INHIBIT_B_BIT],
                    host_control_word_q[`CW_INHIBIT_A_BIT]};

  // three independent channels, each with its own code and stop thresholds
  for (genvar g = 0; g < 3; g++) begin : g_ch
    vent_channel u_ch (
      .clk(CORE_CLK),
      .rst(RESET),
      .func_code(func_q[g]),
      .inhibit(inhibit[g]),
      .vin('{supply_fail: fail_s,
             stop_cmd: !host_control_word_q[`CW_START_BIT],
             freq: freq_s}),
      .pf_th('{upper: upper_pf_q, lower: lower_pf_q}),
      .stop_th('{upper: upper_q[g], lower: lower_q[g]}),
      .out_q(acc[g])
    );
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ACCESSORY_OUT_A <= 1'b0;
      ACCESSORY_OUT_B <= 1'b0;
      ACCESSORY_OUT_C <= 1'b0;
    end else begin
      ACCESSORY_OUT_A <= acc[0];
      ACCESSORY_OUT_B <= acc[1];
      ACCESSORY_OUT_C <= acc[2];
    end
  end

  // start is level-gated: pressure reaching the limit stops the pump again
  always_comb begin
    if (pressure_start_enable_q) begin
      run_d = host_control_word_q[`CW_START_BIT] && (pres_s < plimit_q);
    end else begin
      run_d = host_control_word_q[`CW_START_BIT];
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      PUMP_RUN <= 1'b0;
    end else begin
      PUMP_RUN <= run_d;
    end
  end
endmodule : vent_ctrl

// File: rtl/vent_sync.sv
// Purpose: two-stage synchroniser for a bundle of pin levels
// Assumes: inputs are quasi-static levels from outside the clock domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module vent_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : vent_sync
